/* File: supply_host_model.sv */
/*
  system side: enable driver and the shared status lines.
  assumes one supply on the lines; pg pulled down, alert pulled up.
*/
`timescale 1ns/1ps
`default_nettype none
module supply_host_model (
  input wire logic clk,
  input wire logic want_on,
  input wire logic power_good,
  input wire logic power_good_oe,
  input wire logic alert_request_n,
  input wire logic alert_request_oe,
  output logic enable_n,
  output logic pg_line,
  output logic alert_line
);
  initial enable_n = 1'b1;
  always @(posedge clk) enable_n <= #2 ~want_on;
  // each line follows the single driver while it drives; pg pulled low, alert pulled high when nobody drives
  assign pg_line = power_good_oe ? power_good : 1'b0;
  assign alert_line = alert_request_oe ? alert_request_n : 1'b1;
endmodule // supply_host_model
`default_nettype wire

/* File: supply_status_asserts.sv */
/*
  port checker for the supply status sequencer.
  assumes the design's clk/srst and a shortened millisecond tick.
*/
`timescale 1ns/1ps
`default_nettype none
module supply_status_asserts #(
  parameter int unsigned CYCLES_PER_MS = 4,
  parameter logic [10:0] PG_ON_MS = 11'h096,
  parameter logic [10:0] DWELL_MS = 11'h04B
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic main_output_enable_n,
  input wire supply_status_pkg::sense_t sense,
  input wire logic power_good,
  input wire logic power_good_oe,
  input wire logic alert_request_n,
  input wire logic alert_request_oe,
  input wire logic vin_good,
  input wire supply_status_pkg::drive_t drive
);
  localparam int OFF_MAX = 5 * CYCLES_PER_MS + 4;
  localparam int PG_MIN = (int'(PG_ON_MS) - 1) * CYCLES_PER_MS;
  localparam int DWELL_MIN = (int'(DWELL_MS) - 1) * CYCLES_PER_MS;
  int low_cnt;
  int ok_cnt;
  logic was_good;
  logic shut;
  assign shut = sense.general_fail | sense.over_current | sense.over_voltage | sense.fan_fail;
  // lower bounds only: extra hold-offs in the design may lengthen, never shorten
  always_ff @(posedge clk) begin
    if (srst) begin
      low_cnt <= 0;
      ok_cnt <= 0;
      was_good <= 1'b0;
    end else begin
      low_cnt <= vin_good ? 0 : low_cnt + 1;
      ok_cnt <= (sense.main_reg_ok && vin_good && !sense.current_limit) ? ok_cnt + 1 : 0;
      was_good <= was_good | vin_good;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_drop;
    power_good ##1 $rose(main_output_enable_n);
  endsequence
  a_oe_follows_pg: assert property (power_good_oe == power_good) else $error("pg enable mismatch");
  a_led_with_alert: assert property (drive.fault_led_steady == alert_request_oe) else $error("led off alert");
  a_shutdown_alert: assert property (shut |-> ##[1:2] alert_request_oe) else $error("no alert");
  a_ovp_drops_vin: assert property (sense.vin_over |=> !vin_good) else $error("vin good on ovp");
  a_rail_drops_pg: assert property (!sense.main_reg_ok |=> !power_good) else $error("pg without rail");
  a_release_pg_off: assert property (s_drop |-> ##[0:OFF_MAX] !power_good) else $error("pg late off");
  a_pg_delay_min: assert property ($rose(power_good) |-> ok_cnt >= PG_MIN) else $error("pg early");
  a_dwell_min: assert property ($rose(vin_good) && was_good |-> low_cnt >= DWELL_MIN) else $error("short dwell");
endmodule // supply_status_asserts
bind supply_status_sequencer supply_status_asserts #(.CYCLES_PER_MS(CYCLES_PER_MS), .PG_ON_MS(PG_ON_MS),
  .DWELL_MS(DWELL_MS)) i_supply_status_asserts (.clk(clk), .srst(srst),
  .main_output_enable_n(main_output_enable_n), .sense(sense), .power_good(power_good),
  .power_good_oe(power_good_oe), .alert_request_n(alert_request_n), .alert_request_oe(alert_request_oe),
  .vin_good(vin_good), .drive(drive));
`default_nettype wire

/* File: supply_status_pkg.sv */
/*
  constants and carrier types for the supply status sequencer.
  assumes a single 20 MHz clock; timing is counted in millisecond ticks, except the input measurement, which counts line cycles.
*/
package supply_status_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned CYCLES_PER_MS = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned TICK_W = 15;

  localparam int unsigned MS_W = 11;
  localparam logic [10:0] LEAD_MS = 11'h004;
  localparam logic [10:0] DWELL_MIN_MS = 11'h04B;
  localparam logic [10:0] DWELL_MAX_MS = 11'h078;
  localparam logic [10:0] VIN_ON_MAX_MS = 11'h6A4;
  localparam logic [10:0] STBY_FAULT_MS = 11'h00A;
  localparam logic [10:0] PG_OFF_MAX_MS = 11'h005;
  localparam logic [10:0] PG_ON_MIN_MS = 11'h064;
  localparam logic [10:0] PG_ON_MAX_MS = 11'h1F4;
  localparam logic [10:0] PG_ON_MS = 11'h096;
  localparam logic [10:0] RAIL_OFF_LEAD_MS = 11'h001;
  localparam logic [10:0] MEAS_CYCLES = 11'h005;
  localparam logic [6:0] INLET_WARN_C = 7'h3B;

  typedef struct packed {
    logic main_reg_ok;
    logic standby_ok;
    logic current_limit;
    logic vin_rms_ok;
    logic vin_over;
    logic vin_loss;
    logic line_cycle;
    logic rms_avg_ok;
    logic sense_short;
    logic over_current;
    logic over_voltage;
    logic under_voltage;
    logic general_fail;
    logic fan_slow;
    logic fan_fail;
    logic hotspot_warn;
    logic hotspot_shut;
    logic [6:0] inlet_temp_c;
    logic fan_at_max;
  } sense_t;

  typedef struct packed {
    logic main_rail_on;
    logic fan_max_cmd;
    logic fault_led_steady;
    logic warn_led_blink;
  } drive_t;

  typedef enum logic [1:0] {
    VIN_WAIT = 2'b00,
    VIN_MEAS = 2'b01,
    VIN_GOOD = 2'b10,
    VIN_DWELL = 2'b11
  } vin_state_t;

  typedef enum logic [1:0] {
    PG_OFF = 2'b00,
    PG_DELAY = 2'b01,
    PG_ON = 2'b10,
    PG_LEAD = 2'b11
  } pg_state_t;
endpackage

/* File: supply_status_sequencer.sv */
/*
  status and control signalling of a front-end supply: main-output enable in,
  power-good, alert request and input-voltage-good out.
  assumes every sense input is already synchronous to clk, except the enable
  pin, which is synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
module supply_status_sequencer #(
  parameter int unsigned CYCLES_PER_MS = supply_status_pkg::CYCLES_PER_MS,
  parameter logic [10:0] PG_ON_MS = supply_status_pkg::PG_ON_MS,
  parameter logic [10:0] DWELL_MS = supply_status_pkg::DWELL_MIN_MS
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic main_output_enable_n,
  input wire supply_status_pkg::sense_t sense,
  output logic power_good,
  output logic power_good_oe,
  output logic alert_request_n,
  output logic alert_request_oe,
  output logic vin_good,
  output var supply_status_pkg::drive_t drive
);
  initial begin
    if (CYCLES_PER_MS < 2 || CYCLES_PER_MS >= (1 << supply_status_pkg::TICK_W))
      $error("CYCLES_PER_MS out of range");
    if (PG_ON_MS < supply_status_pkg::PG_ON_MIN_MS || PG_ON_MS > supply_status_pkg::PG_ON_MAX_MS)
      $error("PG_ON_MS outside power-good delay window");
    if (DWELL_MS < supply_status_pkg::DWELL_MIN_MS || DWELL_MS > supply_status_pkg::DWELL_MAX_MS)
      $error("DWELL_MS outside dwell window");
  end

  typedef struct packed {
    logic en_meta;
    logic en_sync;
    logic en_prev;
    logic [14:0] presc;
    logic tick;
    supply_status_pkg::vin_state_t vin_st;
    logic [10:0] vin_cnt;
    logic [10:0] on_cnt;
    logic vin_good;
    supply_status_pkg::pg_state_t pg_st;
    logic [10:0] pg_cnt;
    logic [10:0] stby_cnt;
    logic fault_latched;
    logic inlet_warn;
    logic fan_max;
    logic power_good;
    logic alert;
    logic main_on;
  } state_t;

  state_t st_r;
  state_t st_nxt;

  function automatic logic [10:0] sat_inc(input logic [10:0] v);
    sat_inc = (v == 11'h7FF) ? v : 11'(v + 11'h001);
  endfunction

  logic enable_req;
  logic shutdown_ev;
  logic warn_ev;
  logic temp_ev;
  logic rails_ok;

  always_comb begin
    st_nxt = st_r;
    st_nxt.en_meta = main_output_enable_n;
    st_nxt.en_sync = st_r.en_meta;
    st_nxt.en_prev = st_r.en_sync;
    // free-running prescaler so every timer shares one tick
    if (st_r.presc == 15'(CYCLES_PER_MS - 1)) begin
      st_nxt.presc = 15'h0000;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.presc = 15'(st_r.presc + 15'h0001);
      st_nxt.tick = 1'b0;
    end

    enable_req = ~st_r.en_sync;

    // standby out-of-band timer, restarts when standby recovers
    if (sense.standby_ok)
      st_nxt.stby_cnt = 11'h000;
    else if (st_r.tick)
      st_nxt.stby_cnt = sat_inc(st_r.stby_cnt);

    // shutdown latches; a fresh enable edge clears them
    shutdown_ev = sense.sense_short | sense.over_current | sense.over_voltage | sense.under_voltage
                | sense.general_fail | sense.fan_fail | sense.hotspot_shut;
    if (shutdown_ev)
      st_nxt.fault_latched = 1'b1;
    else if (st_r.en_prev && !st_r.en_sync)
      st_nxt.fault_latched = 1'b0;

    // inlet warning with recovery below threshold
    st_nxt.inlet_warn = (sense.inlet_temp_c >= supply_status_pkg::INLET_WARN_C);
    temp_ev = st_r.inlet_warn | sense.hotspot_warn;
    st_nxt.fan_max = temp_ev | shutdown_ev;
    // temperature alert only once the fan reports full speed
    warn_ev = (temp_ev & sense.fan_at_max) | sense.fan_slow;
    st_nxt.alert = shutdown_ev | st_r.fault_latched | warn_ev;

    st_nxt.main_on = enable_req & ~st_r.fault_latched & ~shutdown_ev
                   & (st_r.stby_cnt < supply_status_pkg::STBY_FAULT_MS);
    rails_ok = sense.main_reg_ok & sense.standby_ok & st_r.main_on;

    // input-voltage-good sequencer
    if (st_r.tick && st_r.on_cnt != 11'h7FF)
      st_nxt.on_cnt = sat_inc(st_r.on_cnt);
    unique case (st_r.vin_st)
      supply_status_pkg::VIN_WAIT: begin
        st_nxt.vin_good = 1'b0;
        st_nxt.vin_cnt = 11'h000;
        if (sense.standby_ok)
          st_nxt.vin_st = supply_status_pkg::VIN_MEAS;
      end
      supply_status_pkg::VIN_MEAS: begin
        // decision taken within five line cycles
        if (sense.line_cycle)
          st_nxt.vin_cnt = sat_inc(st_r.vin_cnt);
        if (sense.vin_rms_ok && !sense.vin_over) begin
          st_nxt.vin_st = supply_status_pkg::VIN_GOOD;
          st_nxt.vin_good = 1'b1;
        // give up after five line cycles, or when the power-on budget is spent
        end else if (st_r.vin_cnt >= supply_status_pkg::MEAS_CYCLES
                     || st_r.on_cnt >= supply_status_pkg::VIN_ON_MAX_MS) begin
          st_nxt.vin_st = supply_status_pkg::VIN_DWELL;
          st_nxt.vin_cnt = 11'h000;
        end
      end
      supply_status_pkg::VIN_GOOD: begin
        // over-voltage or loss drops input-good immediately
        if (sense.vin_over || sense.vin_loss || !sense.vin_rms_ok) begin
          st_nxt.vin_good = 1'b0;
          st_nxt.vin_st = supply_status_pkg::VIN_DWELL;
          st_nxt.vin_cnt = 11'h000;
        end
      end
      supply_status_pkg::VIN_DWELL: begin
        st_nxt.vin_good = 1'b0;
        if (st_r.tick)
          st_nxt.vin_cnt = sat_inc(st_r.vin_cnt);
        // moving-average check only after the dwell has run
        if (st_r.vin_cnt >= DWELL_MS && sense.rms_avg_ok && !sense.vin_over && !sense.vin_loss) begin
          st_nxt.vin_st = supply_status_pkg::VIN_GOOD;
          st_nxt.vin_good = 1'b1;
        end
      end
    endcase

    // power-good sequencer
    unique case (st_r.pg_st)
      supply_status_pkg::PG_OFF: begin
        st_nxt.power_good = 1'b0;
        st_nxt.pg_cnt = 11'h000;
        if (rails_ok && st_r.vin_good && !sense.current_limit)
          st_nxt.pg_st = supply_status_pkg::PG_DELAY;
      end
      supply_status_pkg::PG_DELAY: begin
        if (!rails_ok || !st_r.vin_good) begin
          st_nxt.pg_st = supply_status_pkg::PG_OFF;
        end else if (sense.current_limit) begin
          st_nxt.pg_cnt = 11'h000;
        end else if (st_r.tick) begin
          st_nxt.pg_cnt = sat_inc(st_r.pg_cnt);
          if (st_r.pg_cnt == 11'(PG_ON_MS - 11'h001)) begin
            st_nxt.pg_st = supply_status_pkg::PG_ON;
            st_nxt.power_good = 1'b1;
          end
        end
      end
      supply_status_pkg::PG_ON: begin
        // rail loss or enable release drops at once, well inside 5 ms
        if (!rails_ok || !enable_req) begin
          st_nxt.pg_st = supply_status_pkg::PG_OFF;
          st_nxt.power_good = 1'b0;
        end else if (!st_r.vin_good) begin
          st_nxt.pg_st = supply_status_pkg::PG_LEAD;
          st_nxt.pg_cnt = 11'h000;
        end
      end
      supply_status_pkg::PG_LEAD: begin
        // hold power-good the warning lead time after input-good fell
        if (st_r.tick)
          st_nxt.pg_cnt = sat_inc(st_r.pg_cnt);
        if (!rails_ok || !enable_req) begin
          st_nxt.pg_st = supply_status_pkg::PG_OFF;
          st_nxt.power_good = 1'b0;
        end else if (st_r.vin_good) begin
          st_nxt.pg_st = supply_status_pkg::PG_ON;
        // one extra tick: the first tick may land right after entry, so >= would give under 4 ms
        end else if (st_r.pg_cnt > supply_status_pkg::LEAD_MS) begin
          st_nxt.pg_st = supply_status_pkg::PG_OFF;
          st_nxt.power_good = 1'b0;
        end
      end
    endcase
    // main rail stays up until the cycle after power-good has gone low
    if (!st_nxt.main_on && st_r.power_good)
      st_nxt.main_on = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r <= '0;
      st_r.en_meta <= 1'b1;
      st_r.en_sync <= 1'b1;
      st_r.en_prev <= 1'b1;
      st_r.vin_st <= supply_status_pkg::VIN_WAIT;
      st_r.pg_st <= supply_status_pkg::PG_OFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  // high-side drive only; a paralleled supply can still pull the line high
  assign power_good = st_r.power_good;
  assign power_good_oe = st_r.power_good;
  // open-drain alert: low while an event stands or a shutdown stays latched
  assign alert_request_n = 1'b0;
  assign alert_request_oe = st_r.alert;
  assign vin_good = st_r.vin_good;
  assign drive.main_rail_on = st_r.main_on;
  assign drive.fan_max_cmd = st_r.fan_max;
  assign drive.fault_led_steady = st_r.alert;
  assign drive.warn_led_blink = 1'b0;
endmodule // supply_status_sequencer
`default_nettype wire

/* File: supply_status_sequencer_test.sv */
/*
  self-checking bench for the supply status sequencer.
  assumes a 4-cycle millisecond so timers stay short.
*/
`timescale 1ns/1ps
`default_nettype none
module supply_status_sequencer_test;
  localparam int CPM = 4;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic want_on = 1'b0;
  logic enable_n, pg_line, alert_line, power_good, power_good_oe, alert_request_n, alert_request_oe, vin_good;
  supply_status_pkg::sense_t sense = '0;
  supply_status_pkg::drive_t drive;
  int failures = 0;
  int n_compared = 0;
  int seed = 32'hF7F1;
  int n;
  int src[$] = '{8, 9, 10, 11, 12, 13, 14, 15, 16};
  always #25 clk = ~clk;
  supply_status_sequencer #(.CYCLES_PER_MS(CPM), .PG_ON_MS(11'h064), .DWELL_MS(11'h04B)) i_supply_status_sequencer (
    .clk(clk), .srst(srst), .main_output_enable_n(enable_n), .sense(sense), .power_good(power_good),
    .power_good_oe(power_good_oe), .alert_request_n(alert_request_n), .alert_request_oe(alert_request_oe),
    .vin_good(vin_good), .drive(drive));
  supply_host_model i_supply_host_model (.clk(clk), .want_on(want_on), .power_good(power_good),
    .power_good_oe(power_good_oe), .alert_request_n(alert_request_n), .alert_request_oe(alert_request_oe),
    .enable_n(enable_n), .pg_line(pg_line), .alert_line(alert_line));
  task tick(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask
  task stop_test;
    $display("failures=%0d n_compared=%0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task chk_n(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      failures++;
      $display("BAD t=%0t got %h exp %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wait_on(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      tick(1);
      n++;
    end
    if (n >= lim) begin
      failures++;
      stop_test;
    end
  endtask
  initial begin
    tick(6);
    srst = 1'b0;
    sense.standby_ok = 1'b1;
    repeat (3) begin
      sense.line_cycle = 1'b1;
      tick(1);
      sense.line_cycle = 1'b0;
      tick(3);
    end
    sense.vin_rms_ok = 1'b1;
    wait_on(vin_good, 1'b1, 20 * CPM);
    chk(power_good, 1'b0);
    sense.current_limit = 1'b1;
    want_on = 1'b1;
    tick(8);
    chk(drive.main_rail_on, 1'b1);
    sense.main_reg_ok = 1'b1;
    tick(200 * CPM);
    chk(power_good, 1'b0);
    sense.current_limit = 1'b0;
    wait_on(power_good, 1'b1, 600 * CPM);
    chk_n(n, 99 * CPM, 500 * CPM);
    chk(pg_line, 1'b1);
    sense.vin_loss = 1'b1;
    sense.vin_rms_ok = 1'b0;
    wait_on(vin_good, 1'b0, 8);
    wait_on(power_good, 1'b0, 10 * CPM);
    chk_n(n, 4 * CPM, 10 * CPM);
    sense.vin_loss = 1'b0;
    sense.vin_rms_ok = 1'b1;
    sense.rms_avg_ok = 1'b1;
    wait_on(vin_good, 1'b1, 130 * CPM);
    chk_n(n, 70 * CPM - 10 * CPM, 121 * CPM);
    wait_on(power_good, 1'b1, 600 * CPM);
    want_on = 1'b0;
    wait_on(power_good, 1'b0, 5 * CPM + 4);
    tick(4);
    chk(drive.main_rail_on, 1'b0);
    want_on = 1'b1;
    sense.fan_at_max = 1'b1;
    tick(8);
    foreach (src[i]) begin
      sense[src[i]] = 1'b1;
      tick(3);
      chk(alert_line, 1'b0);
      chk(drive.fault_led_steady, 1'b1);
      if (src[i] == 16) chk(drive.main_rail_on, 1'b0);
      sense[src[i]] = 1'b0;
      want_on = 1'b0;
      tick(6);
      want_on = 1'b1;
      tick(6);
      chk(alert_line, 1'b1);
    end
    sense.fan_at_max = 1'b0;
    sense.inlet_temp_c = 7'h3B;
    tick(3);
    chk(drive.fan_max_cmd, 1'b1);
    chk(alert_line, 1'b1);
    sense.fan_at_max = 1'b1;
    tick(3);
    chk(alert_line, 1'b0);
    repeat (20) begin
      sense.inlet_temp_c = 7'($unsigned($random(seed)) % 59);
      tick(3);
      chk(alert_line, 1'b1);
    end
    sense.standby_ok = 1'b0;
    tick(12 * CPM);
    chk(drive.main_rail_on, 1'b0);
    sense.vin_over = 1'b1;
    tick(3);
    chk(vin_good, 1'b0);
    stop_test;
  end
endmodule // supply_status_sequencer_test
`default_nettype wire
